// *** core/uepc_pkg.sv ***
package uepc_pkg;

   // ==========================================================
   // array geometry
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // ==========================================================
   // timing, in nanoseconds as printed, and clock rate
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_NS = 200;      // address_access_delay, slowest grade
   localparam int GATE_NS = 50;         // gate_to_data_delay
   localparam int FLOAT_NS = 60;        // output float after gate rises
   localparam int SETUP_NS = 1000;      // address, data, gate, supply setup
   localparam int HOLD_NS = 1000;       // data hold after strobe
   localparam int PULSE_NS = 50000;     // program pulse width

   // cycle counts, least times rounded up
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_PULSES = 10;
   localparam int CNT_W = 16;

   // ==========================================================
   // operations and results
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROG = 2'h1;
   localparam logic [1:0] OP_IDENT = 2'h2;
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_FAIL = 2'h1;

   typedef enum logic [3:0] {
      UEPC_IDLE, UEPC_RSETUP, UEPC_RWAIT, UEPC_RFLOAT, UEPC_VPPUP,
      UEPC_PSETUP, UEPC_PULSE, UEPC_PHOLD, UEPC_VWAIT, UEPC_VFLOAT,
      UEPC_VPPDN, UEPC_DONE
   } uepc_state_type;

endpackage : uepc_pkg

// *** core/uepc_timer.sv ***
// down counter giving a one-cycle expiry pulse
module uepc_timer #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   // status
   output logic expired
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic run;
      logic exp;
   } uepc_tmr_type;

   uepc_tmr_type q, d;

   // refuse a width the down counter cannot serve
   if (WIDTH < 2)
   begin : g_bad_width
      $error("timer width too small");
   end

   // ==========================================================
   // count down after load, pulse when reaching zero
   always_comb
   begin
      d = q;
      d.exp = 1'b0;
      if (load)
      begin
         d.cnt = load_value;
         d.run = 1'b1;
      end
      else if (q.run)
      begin
         if (q.cnt <= WIDTH'(1))
         begin
            d.run = 1'b0;
            d.exp = 1'b1;
            d.cnt = '0;
         end
         else
         begin
            d.cnt = q.cnt - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign expired = q.exp;

endmodule : uepc_timer

// *** core/uepc_host.sv ***
module uepc_host #(
   parameter int PULSE_CYCLES = uepc_pkg::PULSE_CYC,
   parameter int MAX_TRIES = uepc_pkg::MAX_PULSES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // user command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [uepc_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [uepc_pkg::DATA_W-1:0] cmd_data,
   output logic rsp_valid,
   output logic [uepc_pkg::DATA_W-1:0] rsp_data,
   output logic [1:0] rsp_status,
   output logic [3:0] rsp_pulses,
   // memory pins
   output logic [uepc_pkg::ADDR_W-1:0] mem_addr,
   output logic id_select_high_voltage_line,
   output logic select_and_program_strobe_n,
   output logic output_gate_n,
   output logic program_supply_high,
   input wire logic [uepc_pkg::DATA_W-1:0] byte_lines_in,
   output logic [uepc_pkg::DATA_W-1:0] byte_lines_out,
   output logic byte_lines_oe_n
);

   localparam int CW = uepc_pkg::CNT_W;

   typedef struct packed {
      uepc_pkg::uepc_state_type st;
      logic [1:0] op;
      logic [uepc_pkg::ADDR_W-1:0] addr;
      logic [uepc_pkg::DATA_W-1:0] data;
      logic [uepc_pkg::DATA_W-1:0] rdata;
      logic [3:0] tries;
      logic [1:0] status;
      logic sel_n;
      logic gate_n;
      logic vpp;
      logic idhv;
      logic drive;
      logic rvalid;
      logic [7:0] sync1;
      logic [7:0] sync2;
   } uepc_host_type;

   uepc_host_type q, d;
   logic tmr_load;
   logic [CW-1:0] tmr_value;
   logic tmr_done;

   // refuse limits the pulse counter or the timer cannot serve
   if (MAX_TRIES < 1 || MAX_TRIES > 15)
   begin : g_bad_tries
      $error("pulse limit out of range");
   end
   if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CW))
   begin : g_bad_pulse
      $error("pulse length out of range");
   end

   // sized cycle count for the timer load port
   function automatic logic [CW-1:0] cyc(input int n);
      cyc = CW'(n);
   endfunction : cyc

   uepc_timer #(
      .WIDTH(CW)
   ) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .load_value(tmr_value),
      .expired(tmr_done)
   );

   // ==========================================================
   // sequencer
   always_comb
   begin
      d = q;
      d.rvalid = 1'b0;
      tmr_load = 1'b0;
      tmr_value = '0;
      // byte lines come from outside: two flip-flops first
      d.sync1 = byte_lines_in;
      d.sync2 = q.sync1;
      case (q.st)
         uepc_pkg::UEPC_IDLE:
         begin
            // idle: standby, supply at logic level
            d.sel_n = 1'b1;
            d.gate_n = 1'b1;
            d.vpp = 1'b0;
            d.idhv = 1'b0;
            d.drive = 1'b0;
            if (cmd_valid)
            begin
               d.op = cmd_op;
               d.addr = cmd_addr;
               d.data = cmd_data;
               d.tries = '0;
               tmr_load = 1'b1;
               if (cmd_op == uepc_pkg::OP_PROG)
               begin
                  // strobe already high before supply rises
                  d.st = uepc_pkg::UEPC_VPPUP;
                  tmr_value = cyc(uepc_pkg::SETUP_CYC);
               end
               else
               begin
                  if (cmd_op == uepc_pkg::OP_IDENT)
                  begin
                     // id read: all other lines low, lowest line picks
                     d.idhv = 1'b1;
                     d.addr = {{(uepc_pkg::ADDR_W-1){1'b0}},
                        cmd_addr[0]};
                  end
                  d.st = uepc_pkg::UEPC_RSETUP;
                  tmr_value = cyc(1);
               end
            end
         end
         uepc_pkg::UEPC_RSETUP:
         begin
            if (tmr_done)
            begin
               // select and gate low together for read
               d.sel_n = 1'b0;
               d.gate_n = 1'b0;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::ACCESS_CYC + 2);
               d.st = uepc_pkg::UEPC_RWAIT;
            end
         end
         uepc_pkg::UEPC_RWAIT:
         begin
            if (tmr_done)
            begin
               d.rdata = q.sync2;
               d.status = uepc_pkg::ST_OK;
               d.gate_n = 1'b1;
               d.sel_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::FLOAT_CYC);
               d.st = uepc_pkg::UEPC_RFLOAT;
            end
         end
         uepc_pkg::UEPC_RFLOAT:
         begin
            if (tmr_done)
            begin
               d.idhv = 1'b0;
               d.st = uepc_pkg::UEPC_DONE;
            end
         end
         uepc_pkg::UEPC_VPPUP:
         begin
            // supply high, gate high: programming mode
            d.vpp = 1'b1;
            d.gate_n = 1'b1;
            if (tmr_done)
            begin
               d.st = uepc_pkg::UEPC_PSETUP;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::SETUP_CYC);
            end
         end
         uepc_pkg::UEPC_PSETUP:
         begin
            // present data on byte lines, select still high
            d.drive = 1'b1;
            d.gate_n = 1'b1;
            d.sel_n = 1'b1;
            if (tmr_done)
            begin
               d.sel_n = 1'b0;
               d.tries = q.tries + 4'h1;
               tmr_load = 1'b1;
               tmr_value = cyc(PULSE_CYCLES);
               d.st = uepc_pkg::UEPC_PULSE;
            end
         end
         uepc_pkg::UEPC_PULSE:
         begin
            if (tmr_done)
            begin
               // discrete pulse ends by timer, never static low
               d.sel_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::HOLD_CYC);
               d.st = uepc_pkg::UEPC_PHOLD;
            end
         end
         uepc_pkg::UEPC_PHOLD:
         begin
            if (tmr_done)
            begin
               // release bus and set gate low in the same cycle for verify
               d.drive = 1'b0;
               d.gate_n = 1'b0;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::ACCESS_CYC + 2);
               d.st = uepc_pkg::UEPC_VWAIT;
            end
         end
         uepc_pkg::UEPC_VWAIT:
         begin
            if (tmr_done)
            begin
               d.rdata = q.sync2;
               d.gate_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::FLOAT_CYC);
               d.st = uepc_pkg::UEPC_VFLOAT;
            end
         end
         uepc_pkg::UEPC_VFLOAT:
         begin
            if (tmr_done)
            begin
               tmr_load = 1'b1;
               tmr_value = cyc(uepc_pkg::SETUP_CYC);
               if (q.rdata == q.data)
               begin
                  d.status = uepc_pkg::ST_OK;
                  d.st = uepc_pkg::UEPC_VPPDN;
               end
               else if (q.tries >= 4'(MAX_TRIES))
               begin
                  d.status = uepc_pkg::ST_FAIL;
                  d.st = uepc_pkg::UEPC_VPPDN;
               end
               else
               begin
                  d.st = uepc_pkg::UEPC_PSETUP;
               end
            end
         end
         uepc_pkg::UEPC_VPPDN:
         begin
            // drop supply back to logic level before finishing
            d.vpp = 1'b0;
            if (tmr_done)
            begin
               d.st = uepc_pkg::UEPC_DONE;
            end
         end
         uepc_pkg::UEPC_DONE:
         begin
            d.rvalid = 1'b1;
            d.st = uepc_pkg::UEPC_IDLE;
         end
         default:
         begin
            d.st = uepc_pkg::UEPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.st <= uepc_pkg::UEPC_IDLE;
         q.sel_n <= 1'b1;
         q.gate_n <= 1'b1;
         q.rdata <= uepc_pkg::ERASED_BYTE;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign cmd_ready = (q.st == uepc_pkg::UEPC_IDLE);
   assign rsp_valid = q.rvalid;
   assign rsp_data = q.rdata;
   assign rsp_status = q.status;
   assign rsp_pulses = q.tries;
   assign mem_addr = q.addr;
   assign id_select_high_voltage_line = q.idhv;
   assign select_and_program_strobe_n = q.sel_n;
   assign output_gate_n = q.gate_n;
   assign program_supply_high = q.vpp;
   assign byte_lines_out = q.data;
   assign byte_lines_oe_n = ~q.drive;

endmodule : uepc_host

// *** bench/uepc_host_sva.sv ***
module uepc_host_sva #(
   parameter int PULSE_CYCLES = uepc_pkg::PULSE_CYC,
   parameter int MAX_TRIES = uepc_pkg::MAX_PULSES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // command side
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic [1:0] rsp_status,
   input wire logic [3:0] rsp_pulses,
   // memory pins
   input wire logic [uepc_pkg::ADDR_W-1:0] mem_addr,
   input wire logic id_select_high_voltage_line,
   input wire logic select_and_program_strobe_n,
   input wire logic output_gate_n,
   input wire logic program_supply_high,
   input wire logic [uepc_pkg::DATA_W-1:0] byte_lines_out,
   input wire logic byte_lines_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] low_q;
   logic [15:0] low_d;

   // ==========
   // length of the running program pulse
   always_comb
   begin
      low_d = 16'h0000;
      if (!select_and_program_strobe_n && program_supply_high)
         low_d = low_q + 16'h0001;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         low_q <= 16'h0000;
      else
         low_q <= low_d;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========
   // pin protocol checks
   pulse_width_a: assert property (
      $rose(select_and_program_strobe_n) && program_supply_high
      |-> low_q >= PULSE_CYCLES && low_q <= PULSE_CYCLES + 1)
      else $error("program pulse width wrong");
   no_dc_strobe_a: assert property (
      low_q <= PULSE_CYCLES + 1)
      else $error("strobe held low too long");
   prog_gate_a: assert property (
      !select_and_program_strobe_n && program_supply_high
      |-> output_gate_n && !byte_lines_oe_n)
      else $error("pulse without gate high and data");
   drive_gate_a: assert property (
      !byte_lines_oe_n |-> output_gate_n)
      else $error("host drives while gate low");
   pulse_stable_a: assert property (
      !select_and_program_strobe_n && program_supply_high
      |-> $stable(mem_addr) && $stable(byte_lines_out))
      else $error("address or data moved in pulse");
   supply_idle_a: assert property (
      cmd_ready |-> !program_supply_high)
      else $error("supply high while idle");
   strobe_first_a: assert property (
      $rose(program_supply_high) |-> select_and_program_strobe_n [*8])
      else $error("strobe low at supply rise");
   id_lines_a: assert property (
      id_select_high_voltage_line
      |-> mem_addr[14:1] == 14'h0000 && !program_supply_high)
      else $error("id read with other lines set");
   fail_limit_a: assert property (
      rsp_valid |-> rsp_pulses <= MAX_TRIES
      && (rsp_status != uepc_pkg::ST_FAIL || rsp_pulses == MAX_TRIES))
      else $error("pulse count wrong");
endmodule : uepc_host_sva

bind uepc_host uepc_host_sva #(
   .PULSE_CYCLES(PULSE_CYCLES),
   .MAX_TRIES(MAX_TRIES)
) u_sva (
   .core_clk(core_clk), .rst_n(rst_n), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp_status(rsp_status),
   .rsp_pulses(rsp_pulses), .mem_addr(mem_addr),
   .id_select_high_voltage_line(id_select_high_voltage_line),
   .select_and_program_strobe_n(select_and_program_strobe_n),
   .output_gate_n(output_gate_n),
   .program_supply_high(program_supply_high),
   .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n)
);

// *** bench/uepc_mem_model.sv ***
module uepc_mem_model #(
   parameter logic [7:0] MAKER_CODE = 8'hA7, // arbitrary value
   parameter logic [7:0] TYPE_CODE = 8'h3C // arbitrary value
) (
   // pins from the host
   input wire logic [uepc_pkg::ADDR_W-1:0] mem_addr,
   input wire logic id_select_high_voltage_line,
   input wire logic select_and_program_strobe_n,
   input wire logic output_gate_n,
   input wire logic program_supply_high,
   input wire logic [uepc_pkg::DATA_W-1:0] byte_lines_out,
   input wire logic byte_lines_oe_n,
   // resolved byte lines
   output logic [uepc_pkg::DATA_W-1:0] byte_lines_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cells [0:32767];
   logic [7:0] word, last;
   logic drive;

   // ==========
   // erased array holds all ones
   initial
   begin
      for (int i = 0; i < 32768; i++)
         cells[i] = 8'hFF;
      last = 8'h00;
   end

   // read: select and gate low; verify: supply high, select high
   assign drive = !output_gate_n && (program_supply_high ?
      select_and_program_strobe_n : !select_and_program_strobe_n);
   assign word = !id_select_high_voltage_line ? cells[mem_addr] :
      (mem_addr[0] ? TYPE_CODE : MAKER_CODE);
   // data lags the gate; released lines keep toggling
   assign #(uepc_pkg::GATE_NS) byte_lines_in = !byte_lines_oe_n ?
      byte_lines_out : (drive ? word : ~last);
   always @(byte_lines_in)
      last = byte_lines_in;

   // end of a pulse with supply and gate high clears bits
   always @(posedge select_and_program_strobe_n)
   begin
      if (program_supply_high && output_gate_n)
         cells[mem_addr] = cells[mem_addr] & byte_lines_in;
   end
endmodule : uepc_mem_model

// *** bench/uv_eprom_read_program_control_test.sv ***
module uv_eprom_read_program_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER_CODE = 8'h5B; // arbitrary value
   localparam logic [7:0] TYPE_CODE = 8'hC6; // arbitrary value
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [14:0] cmd_addr = 15'h0000;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready, rsp_valid, idhv, sel_n, gate_n, vpp, oe_n;
   logic [7:0] rsp_data, bin, bout, q;
   logic [1:0] rsp_status, st;
   logic [3:0] rsp_pulses, np;
   logic [14:0] maddr;
   int fails = 0;
   int checked = 0;
   `define CHK(act, exp, msg) \
      begin \
         checked++; \
         if ((act) !== (exp)) \
         begin \
            fails++; \
            $display("[FAIL] %0t ns %s", $time, msg); \
         end \
      end

   always #(uepc_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   uepc_host #(.PULSE_CYCLES(20)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_status(rsp_status), .rsp_pulses(rsp_pulses), .mem_addr(maddr),
      .id_select_high_voltage_line(idhv),
      .select_and_program_strobe_n(sel_n), .output_gate_n(gate_n),
      .program_supply_high(vpp), .byte_lines_in(bin),
      .byte_lines_out(bout), .byte_lines_oe_n(oe_n));

   uepc_mem_model #(.MAKER_CODE(MAKER_CODE), .TYPE_CODE(TYPE_CODE)) mem (
      .mem_addr(maddr), .id_select_high_voltage_line(idhv),
      .select_and_program_strobe_n(sel_n), .output_gate_n(gate_n),
      .program_supply_high(vpp), .byte_lines_out(bout),
      .byte_lines_oe_n(oe_n), .byte_lines_in(bin));

   // ==========
   // one command, result captured in q, st, np
   task automatic run_cmd(input logic [1:0] op, input logic [14:0] a,
      input logic [7:0] d);
      int n;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      n = 0;
      // look at ready where it has settled, then let the taking edge pass
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && n < 100)
      begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      @(negedge core_clk);
      `CHK(cmd_ready, 1'b0, "busy not shown")
      n = 0;
      while (rsp_valid !== 1'b1 && n < 6000)
      begin
         @(negedge core_clk);
         n++;
      end
      `CHK(rsp_valid, 1'b1, "no response")
      q = rsp_data;
      st = rsp_status;
      np = rsp_pulses;
      // hand back on a rising edge so the next drive lands there
      @(posedge core_clk);
   endtask : run_cmd

   // erased part reads ones at the top address
   task automatic t_erased();
      run_cmd(uepc_pkg::OP_READ, 15'h7FFF, 8'h00);
      `CHK({st, q}, {uepc_pkg::ST_OK, 8'hFF}, "erased byte")
   endtask : t_erased

   // both identification bytes
   task automatic t_ident();
      run_cmd(uepc_pkg::OP_IDENT, 15'h7FFE, 8'h00);
      `CHK(q, MAKER_CODE, "maker code")
      run_cmd(uepc_pkg::OP_IDENT, 15'h0001, 8'h00);
      `CHK(q, TYPE_CODE, "type code")
   endtask : t_ident

   // program, verify, read back, then clear further bits
   task automatic t_program();
      run_cmd(uepc_pkg::OP_PROG, 15'h4321, 8'hA5);
      `CHK({st, np, q}, {uepc_pkg::ST_OK, 4'h1, 8'hA5}, "program")
      run_cmd(uepc_pkg::OP_READ, 15'h4321, 8'h00);
      `CHK(q, 8'hA5, "read back")
      run_cmd(uepc_pkg::OP_READ, 15'h0321, 8'h00);
      `CHK(q, 8'hFF, "alias address")
      run_cmd(uepc_pkg::OP_PROG, 15'h4321, 8'h21);
      `CHK({st, np, q}, {uepc_pkg::ST_OK, 4'h1, 8'h21}, "clear")
   endtask : t_program

   // setting bits again cannot verify: pulse limit
   task automatic t_fail();
      run_cmd(uepc_pkg::OP_PROG, 15'h4321, 8'hDE);
      `CHK({st, np, q}, {uepc_pkg::ST_FAIL, 4'hA, 8'h00}, "limit")
      run_cmd(uepc_pkg::OP_READ, 15'h4321, 8'h00);
      `CHK(q, 8'h00, "failed byte")
   endtask : t_fail

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   // ==========
   // main sequence and watchdog
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_erased();
      t_ident();
      t_program();
      t_fail();
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      fails++;
      stop_test();
   end
endmodule : uv_eprom_read_program_control_test
